// *** test_uart_line_status_flags.sv ***
// Self-checking bench of the line status flag logic.
`timescale 1ns/1ps
module test_uart_line_status_flags;
  typedef struct packed {logic fm, wr, ld, busy, tfe, err, rd; logic [3:0] exp;} ulsf_row_t;
  logic clk, rst_b, ce, fm, rxp, cd, sok, pok, ffe, err, wr, ld, busy, tfe, ien, rd;
  logic hw, hr, he, bpa, irq;
  logic [2:0] top;
  logic [7:0] ls;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Rows run in order: each leaves state that the next one builds on.
  ulsf_row_t rows [10] = '{11'h240, 11'h1C3, 11'h0C3, 11'h047, 11'h600,
    11'h480, 11'h4C3, 11'h447, 11'h46F, 11'h457};
  ulsf_host_model i_ulsf_host_model (.rst_b(rst_b), .do_write(wr), .do_read(rd),
    .irq_on(ien), .host_write_hold(hw), .host_read_status(hr), .hold_irq_enable(he));
  ulsf_line_status i_ulsf_line_status (.clk(clk), .rst_b(rst_b), .ce(ce),
    .fifo_mode(fm), .rx_pin(rxp), .rx_char_done(cd), .rx_stop_ok(sok),
    .rx_parity_ok(pok), .rx_fifo_push(1'h0), .rx_fifo_pop(1'h0), .rx_fifo_empty(ffe),
    .rx_top_errors(top), .rx_fifo_err_any(err), .host_write_hold(hw),
    .tx_load_shift(ld), .tx_shift_busy(busy), .tx_fifo_empty(tfe),
    .hold_irq_enable(he), .host_read_status(hr), .line_status(ls),
    .break_push_allow(bpa), .tx_irq(irq));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  initial begin
    {fm, cd, err, wr, ld, busy, rd, top} = '0;
    {ce, rxp, sok, pok, ffe, tfe, ien} = '1;
    rst_b = 0;
    repeat (4) @(posedge clk);
    #1;
    check("reset", ls, 8'h60);
    rst_b = 1;
    foreach (rows[i]) begin
      {fm, wr, ld, busy, tfe, err, rd} = rows[i][10:4];
      tick();
      check("row", {4'h0, ls[7:5], irq}, {4'h0, rows[i].exp});
    end
    {wr, rd} = '0;
    ien = 0;
    #1 check("irq off", {7'h0, irq}, 8'h00);
    {fm, ien, pok, cd} = 4'h5;
    tick();
    {cd, pok} = 2'h1;
    check("parity", ls & 8'h9C, 8'h84);
    rd = 1;
    tick();
    rd = 0;
    check("read clear", ls & 8'h9C, 8'h00);
    {sok, cd} = 2'h1;
    tick();
    {sok, cd} = 2'h2;
    check("framing", ls & 8'h9C, 8'h88);
    {rxp, rd} = 2'h1;
    tick();
    rd = 0;
    repeat (2) tick();
    {sok, cd} = 2'h1;
    tick();
    {sok, cd} = 2'h2;
    check("break", ls & 8'h10, 8'h10);
    rxp = 1;
    repeat (3) tick();
    {rxp, fm, ffe, top} = 6'h17;
    repeat (3) tick();
    {sok, cd} = 2'h1;
    #1 check("first break", {7'h0, bpa}, 8'h01);
    tick();
    cd = 0;
    check("top errors", ls & 8'h1C, 8'h1C);
    tick();
    cd = 1;
    #1 check("repeat break", {7'h0, bpa}, 8'h00);
    tick();
    {cd, sok, rxp} = 3'h3;
    {ce, rd} = 2'h1;
    tick();
    check("freeze", ls, 8'hFC);
    rst_b = 0;
    #1 check("mid reset", {ls[7:1], irq}, 8'h61);
    tally_and_finish();
  end
endmodule : test_uart_line_status_flags

// *** ulsf_host_model.sv ***
// Host CPU model that strobes status reads and holding register writes.
`timescale 1ns/1ps
module ulsf_host_model (
  input wire logic rst_b,
  input wire logic do_write,
  input wire logic do_read,
  input wire logic irq_on,
  output logic host_write_hold,
  output logic host_read_status,
  output logic hold_irq_enable
);
  // Accesses are gated off in reset, since the device takes none before release.
  assign host_write_hold = rst_b & do_write;
  assign host_read_status = rst_b & do_read;
  assign hold_irq_enable = irq_on;
endmodule : ulsf_host_model

// *** ulsf_line_status.sv ***
// Line status flags of the UART: error summary, transmit empties, break and frame errors.
`timescale 1ns/1ps
// Behaviour
// R1: Error summary sets while any receive FIFO character carries parity, framing or break.
// R2: Reading the line status register clears the error summary flag.
// R3: Error summary reads 0 when no receive error is present.
// R4: Non-FIFO mode: transmitter empty is 1 when holding and shift registers are empty.
// R5: Transmitter empty drops to 0 when holding or shift register holds a character.
// R6: FIFO mode: transmitter empty is 1 only when transmit FIFO and shifter empty.
// R7: Non-FIFO mode: holding empty sets when a character moves into the shifter.
// R8: Holding empty clears in the cycle the host writes the holding register; the code shows it at 0 from the next cycle.
// R9: Holding empty with its interrupt enable raises a transmit interrupt request.
// R10: FIFO mode: holding empty equals transmit FIFO empty.
// R11: FIFO mode: holding empty clears once the host writes a byte to the FIFO.
// R12: Break flag sets after a low frame; only one break character enters the FIFO.
// R13: Framing error flag sets on a missing stop bit, for the FIFO top character.
// R14: Parity error flag sets on bad parity, for the FIFO top character.
// R15: Transmit interrupt withdraws when holding empty clears or its enable is off.
module ulsf_line_status (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic fifo_mode,
  input wire logic rx_pin,
  input wire logic rx_char_done,
  input wire logic rx_stop_ok,
  input wire logic rx_parity_ok,
  input wire logic rx_fifo_push,
  input wire logic rx_fifo_pop,
  input wire logic rx_fifo_empty,
  input wire logic [2:0] rx_top_errors,
  input wire logic rx_fifo_err_any,
  input wire logic host_write_hold,
  input wire logic tx_load_shift,
  input wire logic tx_shift_busy,
  input wire logic tx_fifo_empty,
  input wire logic hold_irq_enable,
  input wire logic host_read_status,
  output logic [7:0] line_status,
  output logic break_push_allow,
  output logic tx_irq
);
  typedef struct packed {
    logic fifo_error_summary;
    logic holding_empty;
    logic hold_full;
    logic break_detected;
    logic framing_error;
    logic parity_error;
    logic in_break;
    logic [7:0] status_q;
  } ulsf_state_t;

  ulsf_state_t st;
  ulsf_state_t next_st;
  logic rx_sync;
  logic tx_empty_now;

  ulsf_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d(rx_pin),
    .q(rx_sync)
  );

  function automatic logic is_break(input logic line, input logic stop_ok);
    is_break = !line && !stop_ok;
  endfunction : is_break

  always_comb begin
    next_st = st;
    tx_empty_now = 1'b0;
    if (ce) begin
      if (host_read_status) begin
        next_st.fifo_error_summary = 1'b0; // [R2]
      end
      if (host_write_hold) begin
        next_st.hold_full = 1'b1;
      end else if (tx_load_shift) begin
        next_st.hold_full = 1'b0;
      end
      if (fifo_mode) begin
        next_st.holding_empty = tx_fifo_empty && !host_write_hold; // [R10] [R11]
      end else if (host_write_hold) begin
        next_st.holding_empty = 1'b0; // [R8]
      end else if (tx_load_shift) begin
        next_st.holding_empty = 1'b1; // [R7]
      end
      if (rx_sync) begin
        next_st.in_break = 1'b0;
      end
      if (fifo_mode) begin
        next_st.parity_error = !rx_fifo_empty && rx_top_errors[0]; // [R14]
        next_st.framing_error = !rx_fifo_empty && rx_top_errors[1]; // [R13]
        next_st.break_detected = !rx_fifo_empty && rx_top_errors[2]; // [R12]
        if (rx_char_done && is_break(rx_sync, rx_stop_ok)) begin
          next_st.in_break = 1'b1; // [R12]
        end
      end else begin
        if (host_read_status) begin
          next_st.parity_error = 1'b0;
          next_st.framing_error = 1'b0;
          next_st.break_detected = 1'b0;
        end
        if (rx_char_done) begin
          if (!rx_parity_ok) next_st.parity_error = 1'b1; // [R14]
          if (!rx_stop_ok) next_st.framing_error = 1'b1; // [R13]
          if (is_break(rx_sync, rx_stop_ok)) next_st.break_detected = 1'b1; // [R12]
        end
      end
      // In non-FIFO mode the summary follows the updated flags, so a read that clears them clears it too.
      if (fifo_mode ? rx_fifo_err_any
                    : (next_st.parity_error | next_st.framing_error | next_st.break_detected)) begin
        next_st.fifo_error_summary = 1'b1; // [R1] [R3]
      end
      tx_empty_now = fifo_mode ? (tx_fifo_empty && !tx_shift_busy && !host_write_hold) // [R6]
                               : (!next_st.hold_full && !tx_shift_busy); // [R4] [R5]
      next_st.status_q = '0;
      next_st.status_q[ulsf_pkg::BIT_FIFO_ERR] = next_st.fifo_error_summary;
      next_st.status_q[ulsf_pkg::BIT_TX_EMPTY] = tx_empty_now;
      next_st.status_q[ulsf_pkg::BIT_HOLD_EMPTY] = next_st.holding_empty;
      next_st.status_q[ulsf_pkg::BIT_BREAK] = next_st.break_detected;
      next_st.status_q[ulsf_pkg::BIT_FRAME] = next_st.framing_error;
      next_st.status_q[ulsf_pkg::BIT_PARITY] = next_st.parity_error;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.holding_empty <= 1'b1;
      st.status_q <= ulsf_pkg::LS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Only the first character of a break burst may enter the FIFO, so the line stays quiet.
  assign break_push_allow = !(fifo_mode && st.in_break && rx_char_done); // [R12]
  assign line_status = st.status_q;
  assign tx_irq = st.holding_empty && hold_irq_enable; // [R9] [R15]

  property p_hold_clear;
    @(posedge clk) disable iff (!rst_b)
    (ce && host_write_hold) |=> !line_status[ulsf_pkg::BIT_HOLD_EMPTY];
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("Holding empty not cleared by write."); // [R8]

  property p_hold_set;
    @(posedge clk) disable iff (!rst_b)
    (ce && !fifo_mode && tx_load_shift && !host_write_hold) |=> line_status[ulsf_pkg::BIT_HOLD_EMPTY];
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("Holding empty not set on shift load."); // [R7]

  property p_fifo_hold;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode) |=> (line_status[ulsf_pkg::BIT_HOLD_EMPTY] == $past(tx_fifo_empty && !host_write_hold));
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("Holding empty differs from FIFO empty."); // [R10]

  property p_read_clear;
    @(posedge clk) disable iff (!rst_b)
    (ce && host_read_status && !fifo_mode && !rx_char_done && !st.parity_error && !st.framing_error
      && !st.break_detected)
      |=> !line_status[ulsf_pkg::BIT_FIFO_ERR];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Error summary not cleared on read."); // [R2]

  property p_err_set;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && rx_fifo_err_any) |=> line_status[ulsf_pkg::BIT_FIFO_ERR];
  endproperty
  a_err_set: assert property (p_err_set) else $error("Error summary missed a FIFO error."); // [R1]

  property p_tx_empty;
    @(posedge clk) disable iff (!rst_b)
    (ce && tx_shift_busy) |=> !line_status[ulsf_pkg::BIT_TX_EMPTY];
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("Transmitter empty while shifting."); // [R5]

  property p_tx_empty_fifo;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && !tx_fifo_empty) |=> !line_status[ulsf_pkg::BIT_TX_EMPTY];
  endproperty
  a_tx_empty_fifo: assert property (p_tx_empty_fifo) else $error("Transmitter empty with FIFO data."); // [R6]

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
    tx_irq == (line_status[ulsf_pkg::BIT_HOLD_EMPTY] && hold_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("Transmit interrupt mismatch."); // [R9]

  property p_frame;
    @(posedge clk) disable iff (!rst_b)
    (ce && !fifo_mode && rx_char_done && !rx_stop_ok) |=> line_status[ulsf_pkg::BIT_FRAME];
  endproperty
  a_frame: assert property (p_frame) else $error("Framing error not flagged."); // [R13]

  sequence s_host_write_nf;
    ce && !fifo_mode && host_write_hold;
  endsequence

  sequence s_shift_load_nf;
    ce && !fifo_mode && tx_load_shift && !host_write_hold;
  endsequence

  sequence s_break_char_fifo;
    ce && fifo_mode && rx_char_done && !rx_sync && !rx_stop_ok;
  endsequence

  sequence s_irq_raised;
    line_status[ulsf_pkg::BIT_HOLD_EMPTY] && hold_irq_enable;
  endsequence

  property p_nf_parity;
    @(posedge clk) disable iff (!rst_b)
    (ce && !fifo_mode && rx_char_done && !rx_parity_ok)
      |=> (line_status[ulsf_pkg::BIT_PARITY] && line_status[ulsf_pkg::BIT_FIFO_ERR]);
  endproperty
  a_nf_parity: assert property (p_nf_parity) else $error("Parity error not flagged."); // [R14]

  property p_fifo_parity;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && !rx_fifo_empty && rx_top_errors[0]) |=> line_status[ulsf_pkg::BIT_PARITY];
  endproperty
  a_fifo_parity: assert property (p_fifo_parity) else $error("Top parity not shown."); // [R14]

  property p_fifo_frame;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && !rx_fifo_empty && rx_top_errors[1]) |=> line_status[ulsf_pkg::BIT_FRAME];
  endproperty
  a_fifo_frame: assert property (p_fifo_frame) else $error("Top framing not shown."); // [R13]

  property p_fifo_break;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && !rx_fifo_empty && rx_top_errors[2]) |=> line_status[ulsf_pkg::BIT_BREAK];
  endproperty
  a_fifo_break: assert property (p_fifo_break) else $error("Top break not shown."); // [R12]

  property p_fifo_top_clear;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && rx_fifo_empty)
      |=> (line_status[ulsf_pkg::BIT_BREAK:ulsf_pkg::BIT_PARITY] == '0);
  endproperty
  a_fifo_top_clear: assert property (p_fifo_top_clear) else $error("Empty FIFO shows errors."); // [R12]

  property p_break_once;
    @(posedge clk) disable iff (!rst_b)
    s_break_char_fifo ##1 (fifo_mode && rx_char_done && !rx_sync) |-> !break_push_allow;
  endproperty
  a_break_once: assert property (p_break_once) else $error("Repeated break allowed in."); // [R12]

  property p_fifo_no_err;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && host_read_status && !rx_fifo_err_any) |=> !line_status[ulsf_pkg::BIT_FIFO_ERR];
  endproperty
  a_fifo_no_err: assert property (p_fifo_no_err) else $error("Summary set without error."); // [R3]

  property p_nf_read_flags;
    @(posedge clk) disable iff (!rst_b)
    (ce && !fifo_mode && host_read_status && !rx_char_done)
      |=> (line_status[ulsf_pkg::BIT_BREAK:ulsf_pkg::BIT_PARITY] == '0);
  endproperty
  a_nf_read_flags: assert property (p_nf_read_flags) else $error("Flags kept after read."); // [R2]

  property p_write_then_load;
    @(posedge clk) disable iff (!rst_b)
    s_host_write_nf ##1 s_shift_load_nf |=> line_status[ulsf_pkg::BIT_HOLD_EMPTY];
  endproperty
  a_write_then_load: assert property (p_write_then_load) else $error("Load did not empty."); // [R7]

  property p_tx_idle_nf;
    @(posedge clk) disable iff (!rst_b)
    (ce && !fifo_mode && !host_write_hold && !tx_shift_busy && !st.hold_full)
      |=> line_status[ulsf_pkg::BIT_TX_EMPTY];
  endproperty
  a_tx_idle_nf: assert property (p_tx_idle_nf) else $error("Transmitter empty not set."); // [R4]

  property p_tx_idle_fifo;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && tx_fifo_empty && !tx_shift_busy && !host_write_hold)
      |=> line_status[ulsf_pkg::BIT_TX_EMPTY];
  endproperty
  a_tx_idle_fifo: assert property (p_tx_idle_fifo) else $error("FIFO transmitter empty unset."); // [R6]

  property p_fifo_write_clear;
    @(posedge clk) disable iff (!rst_b)
    (ce && fifo_mode && host_write_hold)
      |=> (!line_status[ulsf_pkg::BIT_HOLD_EMPTY] && !line_status[ulsf_pkg::BIT_TX_EMPTY]);
  endproperty
  a_fifo_write_clear: assert property (p_fifo_write_clear) else $error("FIFO write kept empty."); // [R11]

  property p_write_tx_busy;
    @(posedge clk) disable iff (!rst_b)
    s_host_write_nf |=> !line_status[ulsf_pkg::BIT_TX_EMPTY];
  endproperty
  a_write_tx_busy: assert property (p_write_tx_busy) else $error("Empty with held character."); // [R5]

  property p_irq_on;
    @(posedge clk) disable iff (!rst_b)
    (s_shift_load_nf and hold_irq_enable) ##1 hold_irq_enable |-> tx_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("Transmit interrupt not raised."); // [R9]

  property p_irq_off;
    @(posedge clk) disable iff (!rst_b)
    s_irq_raised ##1 !hold_irq_enable |-> !tx_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("Transmit interrupt not withdrawn."); // [R15]

  // A low enable must freeze the register even while the host strobes a read.
  property p_freeze;
    @(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(line_status);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Status changed while frozen.");
endmodule : ulsf_line_status

// *** ulsf_pkg.sv ***
// Package of constants shared by the line status flag logic.
package ulsf_pkg;
  localparam int LS_W = 8;
  localparam int BIT_FIFO_ERR = 7;
  localparam int BIT_TX_EMPTY = 6;
  localparam int BIT_HOLD_EMPTY = 5;
  localparam int BIT_BREAK = 4;
  localparam int BIT_FRAME = 3;
  localparam int BIT_PARITY = 2;
  localparam logic [7:0] LS_RESET = 8'h60;
  localparam logic [1:0] SYNC_RESET = 2'h3;
endpackage : ulsf_pkg

// *** ulsf_sync.sv ***
// Two flip-flop synchroniser for the receive line pin.
`timescale 1ns/1ps
module ulsf_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ulsf_sync_t;
  ulsf_sync_t st;
  ulsf_sync_t next_st;
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= ulsf_pkg::SYNC_RESET;
    end else begin
      st <= next_st;
    end
  end
  assign q = st.s2;
endmodule : ulsf_sync
